// ===== hw/opcd_pkg.sv
// Package for the output pair clock divider block.
// Assumes one divider input clock drives the whole block.
package opcd_pkg;

   // Register map, byte offsets on the 10-bit register port
   localparam logic [9:0] OFS_DIV0_LEN   = 10'h190;
   localparam logic [9:0] OFS_DIV0_CTL   = 10'h191;
   localparam logic [9:0] OFS_DIV0_ROUTE = 10'h192;
   localparam logic [9:0] OFS_DIV1_LEN   = 10'h193;
   localparam logic [9:0] OFS_DIV1_CTL   = 10'h194;
   localparam logic [9:0] OFS_DIV1_ROUTE = 10'h195;
   localparam logic [9:0] OFS_STATUS     = 10'h19F;

   // Field positions in the cycle length registers
   localparam int LEN_LOW_MSB  = 7;
   localparam int LEN_LOW_LSB  = 4;
   localparam int LEN_HIGH_MSB = 3;
   localparam int LEN_HIGH_LSB = 0;

   // Field positions in the control registers
   localparam int CTL_BYPASS    = 7;
   localparam int CTL_NOSYNC    = 6;
   localparam int CTL_FORCE     = 5;
   localparam int CTL_START     = 4;
   localparam int CTL_PHASE_MSB = 3;
   localparam int CTL_PHASE_LSB = 0;

   // Field positions in the routing and duty registers
   localparam int ROUTE_DIRECT = 1;
   localparam int ROUTE_DUTY   = 0;

   // Field positions in the status register
   localparam int STAT_LEVEL0 = 0;
   localparam int STAT_LEVEL1 = 1;
   localparam int STAT_WAIT0  = 2;
   localparam int STAT_WAIT1  = 3;

   // Reset values
   localparam logic [7:0] RST_DIV0_LEN   = 8'h00;
   localparam logic [7:0] RST_DIV0_CTL   = 8'h80;
   localparam logic [7:0] RST_DIV0_ROUTE = 8'h00;
   localparam logic [7:0] RST_DIV1_LEN   = 8'h00;
   localparam logic [7:0] RST_DIV1_CTL   = 8'h00;
   localparam logic [7:0] RST_DIV1_ROUTE = 8'h00;

   // Input select codes held outside this block
   localparam logic [1:0] SEL_EXT_CLK = 2'h0;
   localparam logic [1:0] SEL_DIVIDED = 2'h1;
   localparam logic [1:0] SEL_OSC     = 2'h2;

   // Divider input clock
   localparam int CLK_PERIOD_NS = 40;

   // Divider sequencer states
   typedef enum logic [0:0] {
      DIV_RUN  = 1'b0,
      DIV_WAIT = 1'b1
   } opcd_state_t;

endpackage

// ===== hw/opcd_divider.sv
// One channel divider: low/high counting, alignment restart, force, bypass.
// Assumes i_in_level is the sampled level of the selected input clock.
`timescale 1ns/1ns
module opcd_divider (
   input  wire logic       i_clk,
   input  wire logic       i_arst_n,
   input  wire logic [3:0] i_low_len,
   input  wire logic [3:0] i_high_len,
   input  wire logic       i_bypass,
   input  wire logic       i_nosync,
   input  wire logic       i_force_high,
   input  wire logic       i_start_high,
   input  wire logic [3:0] i_phase,
   input  wire logic       i_align,
   input  wire logic       i_in_level,
   output logic            o_level,
   output logic            o_waiting
);
   import opcd_pkg::*;

   opcd_state_t state_reg;          // Run or wait for phase offset
   opcd_state_t state_next;
   logic [3:0]  cnt_reg;            // Cycles left in current phase
   logic [3:0]  cnt_next;
   logic        lvl_reg;            // Divided level
   logic        lvl_next;

   // Obeyed alignment request, gated by the ignore bit
   wire align_take = i_align & ~i_nosync;
   // Static level applies only with the ignore bit set
   wire forced     = i_nosync & i_force_high;
   // Length to load when entering a given level
   wire [3:0] len_for_hi = i_high_len;
   wire [3:0] len_for_lo = i_low_len;

   // Next state selection
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      lvl_next   = lvl_reg;
      if (i_bypass) begin
         // Counter parked; input passes straight through
         state_next = DIV_WAIT;
         cnt_next   = 4'h0;
         lvl_next   = i_in_level;
      end else if (forced) begin
         // Held static; counter kept idle
         state_next = DIV_RUN;
         cnt_next   = 4'h0;
         lvl_next   = 1'b1;
      end else if (align_take) begin
         // Restart after the phase offset
         state_next = DIV_WAIT;
         cnt_next   = i_phase;
         lvl_next   = i_start_high;
      end else begin
         unique case (state_reg)
            DIV_WAIT: begin
               // Hold start level until the offset runs out
               lvl_next = i_start_high;
               if (cnt_reg == 4'h0) begin
                  state_next = DIV_RUN;
                  cnt_next   = i_start_high ? len_for_hi : len_for_lo;
               end else begin
                  cnt_next = cnt_reg - 4'h1;
               end
            end
            DIV_RUN: begin
               // Period is (low+1)+(high+1) input cycles
               if (cnt_reg == 4'h0) begin
                  lvl_next = ~lvl_reg;
                  cnt_next = lvl_reg ? len_for_lo : len_for_hi;
               end else begin
                  cnt_next = cnt_reg - 4'h1;
               end
            end
         endcase
      end
   end

   // State registers; reset parks in wait so first run starts cleanly
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg <= DIV_WAIT;
         cnt_reg   <= 4'h0;
         lvl_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         lvl_reg   <= lvl_next;
      end
   end

   assign o_level   = lvl_reg;
   assign o_waiting = (state_reg == DIV_WAIT) & ~i_bypass;

endmodule

// ===== hw/opcd_top.sv
// Two channel dividers with their registers and output pair routing.
// Assumes i_clk is the selected divider input clock, and that the
// oscillator and external clock arrive as levels sampled on i_clk.
//
// Overview of operation
// - Low time is low field plus one.
// - High time is high field plus one.
// - Divider 1 low field encodes identically.
// - Bypass powers down, passes input; divider 0 bypassed.
// - Divider 1 leaves reset actively dividing.
// - Ignore bit clear means obey alignment request.
// - Force level needs ignore bit set.
// - Start level chosen by start bit.
// - Four-bit phase offset per divider, reset zero.
// - Divider 0 drives pair 0 by default.
// - Direct route picks oscillator or external clock.
// - Duty correction on unless disable bit set.
// - Divider 1 phase and start share control register.
// - Divider 1 drives pair 1, same routing.
`timescale 1ns/1ns
module opcd_top #(
   parameter int ADDR_W = 10             // Register port address width
) (
   input  wire logic              i_clk,
   input  wire logic              i_arst_n,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [7:0]        i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   input  wire logic [1:0]        i_in_select,
   input  wire logic              i_osc_level,
   input  wire logic              i_ext_level,
   input  wire logic              i_align_req,
   output logic [7:0]             o_rdata,
   output logic                   o_pair0_output_a,
   output logic                   o_pair0_output_b,
   output logic                   o_pair1_output_a,
   output logic                   o_pair1_output_b,
   output logic                   o_duty_fix_on0,
   output logic                   o_duty_fix_on1,
   output logic                   o_div0_powered_down,
   output logic                   o_div1_powered_down
);
   import opcd_pkg::*;

   // Refuse an address port too narrow for the map
   if (ADDR_W < 10) begin : g_addr_check
      $error("opcd_top: ADDR_W must be at least 10");
   end

   // Pick what an output pair carries.
   // Code 01 leaves the pair on its divider; 11 is treated the same,
   // since no routing is defined for it.
   function automatic logic route_pick(input logic       direct,
                                       input logic [1:0] sel,
                                       input logic       osc,
                                       input logic       ext,
                                       input logic       div);
      logic r;
      r = div;
      if (direct && sel == SEL_OSC) begin
         r = osc;
      end else if (direct && sel == SEL_EXT_CLK) begin
         r = ext;
      end
      return r;
   endfunction

   // Software visible registers
   logic [7:0] div0_cycle_lengths_reg;   // Low and high lengths, divider 0
   logic [7:0] div0_control_reg;         // Bypass, ignore, force, start, phase
   logic [7:0] div0_routing_duty_reg;    // Direct route and duty disable
   logic [7:0] div1_cycle_lengths_reg;   // Low and high lengths, divider 1
   logic [7:0] div1_control_reg;         // Same layout as divider 0
   logic [7:0] div1_routing_duty_reg;    // Same layout as divider 0

   // Output flops
   logic [7:0] rdata_reg;                // Read data, one cycle after strobe
   logic [7:0] rdata_next;
   logic       pair0_reg;                // Level driven to pair 0
   logic       pair1_reg;                // Level driven to pair 1
   logic       duty0_reg;                // Duty correction enable, pair 0
   logic       duty1_reg;                // Duty correction enable, pair 1
   logic       pd0_reg;                  // Divider 0 powered down
   logic       pd1_reg;                  // Divider 1 powered down

   // Divider results
   logic div0_level;
   logic div1_level;
   logic div0_wait;
   logic div1_wait;

   // Address decode, low ten bits carry the map
   wire [9:0] addr10    = i_addr[9:0];
   wire       hi_clear  = (ADDR_W == 10) ? 1'b1 : (i_addr >> 10) == '0;
   wire       hit_len0  = hi_clear && addr10 == OFS_DIV0_LEN;
   wire       hit_ctl0  = hi_clear && addr10 == OFS_DIV0_CTL;
   wire       hit_rte0  = hi_clear && addr10 == OFS_DIV0_ROUTE;
   wire       hit_len1  = hi_clear && addr10 == OFS_DIV1_LEN;
   wire       hit_ctl1  = hi_clear && addr10 == OFS_DIV1_CTL;
   wire       hit_rte1  = hi_clear && addr10 == OFS_DIV1_ROUTE;
   wire       hit_stat  = hi_clear && addr10 == OFS_STATUS;

   // Write enables per register
   wire we_len0 = i_wr & hit_len0;
   wire we_ctl0 = i_wr & hit_ctl0;
   wire we_rte0 = i_wr & hit_rte0;
   wire we_len1 = i_wr & hit_len1;
   wire we_ctl1 = i_wr & hit_ctl1;
   wire we_rte1 = i_wr & hit_rte1;

   // Live status of both dividers
   wire [7:0] status_word = {4'h0, div1_wait, div0_wait, div1_level, div0_level};

   // Read mux; unmapped addresses read as zero
   always_comb begin
      rdata_next = 8'h00;
      if (hit_len0) begin
         rdata_next = div0_cycle_lengths_reg;
      end else if (hit_ctl0) begin
         rdata_next = div0_control_reg;
      end else if (hit_rte0) begin
         // Only the two defined bits read back
         rdata_next = {6'h00, div0_routing_duty_reg[1:0]};
      end else if (hit_len1) begin
         rdata_next = div1_cycle_lengths_reg;
      end else if (hit_ctl1) begin
         rdata_next = div1_control_reg;
      end else if (hit_rte1) begin
         rdata_next = {6'h00, div1_routing_duty_reg[1:0]};
      end else if (hit_stat) begin
         rdata_next = status_word;
      end
   end

   // Divider 0 register writes
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div0_cycle_lengths_reg <= RST_DIV0_LEN;
         div0_control_reg       <= RST_DIV0_CTL;
         div0_routing_duty_reg  <= RST_DIV0_ROUTE;
      end else begin
         if (we_len0) begin
            div0_cycle_lengths_reg <= i_wdata;
         end
         if (we_ctl0) begin
            div0_control_reg <= i_wdata;
         end
         if (we_rte0) begin
            div0_routing_duty_reg <= i_wdata;
         end
      end
   end

   // Divider 1 register writes
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div1_cycle_lengths_reg <= RST_DIV1_LEN;
         div1_control_reg       <= RST_DIV1_CTL;
         div1_routing_duty_reg  <= RST_DIV1_ROUTE;
      end else begin
         if (we_len1) begin
            div1_cycle_lengths_reg <= i_wdata;
         end
         if (we_ctl1) begin
            div1_control_reg <= i_wdata;
         end
         if (we_rte1) begin
            div1_routing_duty_reg <= i_wdata;
         end
      end
   end

   // Selected input level seen by a bypassed divider.
   // Select code 01 names a path outside this block; the oscillator
   // stands in for it, as the nearest available source.
   wire in_level = (i_in_select == SEL_EXT_CLK) ? i_ext_level : i_osc_level;

   // Divider 0
   opcd_divider u_div0 (
      .i_clk        (i_clk),
      .i_arst_n     (i_arst_n),
      .i_low_len    (div0_cycle_lengths_reg[LEN_LOW_MSB:LEN_LOW_LSB]),
      .i_high_len   (div0_cycle_lengths_reg[LEN_HIGH_MSB:LEN_HIGH_LSB]),
      .i_bypass     (div0_control_reg[CTL_BYPASS]),
      .i_nosync     (div0_control_reg[CTL_NOSYNC]),
      .i_force_high (div0_control_reg[CTL_FORCE]),
      .i_start_high (div0_control_reg[CTL_START]),
      .i_phase      (div0_control_reg[CTL_PHASE_MSB:CTL_PHASE_LSB]),
      .i_align      (i_align_req),
      .i_in_level   (in_level),
      .o_level      (div0_level),
      .o_waiting    (div0_wait)
   );

   // Divider 1, identical layout
   opcd_divider u_div1 (
      .i_clk        (i_clk),
      .i_arst_n     (i_arst_n),
      .i_low_len    (div1_cycle_lengths_reg[LEN_LOW_MSB:LEN_LOW_LSB]),
      .i_high_len   (div1_cycle_lengths_reg[LEN_HIGH_MSB:LEN_HIGH_LSB]),
      .i_bypass     (div1_control_reg[CTL_BYPASS]),
      .i_nosync     (div1_control_reg[CTL_NOSYNC]),
      .i_force_high (div1_control_reg[CTL_FORCE]),
      .i_start_high (div1_control_reg[CTL_START]),
      .i_phase      (div1_control_reg[CTL_PHASE_MSB:CTL_PHASE_LSB]),
      .i_align      (i_align_req),
      .i_in_level   (in_level),
      .o_level      (div1_level),
      .o_waiting    (div1_wait)
   );

   // Pair levels after optional direct routing
   wire pair0_next = route_pick(div0_routing_duty_reg[ROUTE_DIRECT], i_in_select,
                                i_osc_level, i_ext_level, div0_level);
   wire pair1_next = route_pick(div1_routing_duty_reg[ROUTE_DIRECT], i_in_select,
                                i_osc_level, i_ext_level, div1_level);

   // Duty correction runs while its disable bit is clear
   wire duty0_next = ~div0_routing_duty_reg[ROUTE_DUTY];
   wire duty1_next = ~div1_routing_duty_reg[ROUTE_DUTY];

   // Output flops; one extra cycle of latency keeps every pin glitch free
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_reg <= 8'h00;
         pair0_reg <= 1'b0;
         pair1_reg <= 1'b0;
         duty0_reg <= 1'b1;
         duty1_reg <= 1'b1;
         pd0_reg   <= 1'b1;
         pd1_reg   <= 1'b0;
      end else begin
         // Read data only in the cycle after a read strobe
         rdata_reg <= i_rd ? rdata_next : 8'h00;
         pair0_reg <= pair0_next;
         pair1_reg <= pair1_next;
         duty0_reg <= duty0_next;
         duty1_reg <= duty1_next;
         pd0_reg   <= div0_control_reg[CTL_BYPASS];
         pd1_reg   <= div1_control_reg[CTL_BYPASS];
      end
   end

   // Both members of a pair carry the same clock
   assign o_rdata             = rdata_reg;
   assign o_pair0_output_a    = pair0_reg;
   assign o_pair0_output_b    = pair0_reg;
   assign o_pair1_output_a    = pair1_reg;
   assign o_pair1_output_b    = pair1_reg;
   assign o_duty_fix_on0      = duty0_reg;
   assign o_duty_fix_on1      = duty1_reg;
   assign o_div0_powered_down = pd0_reg;
   assign o_div1_powered_down = pd1_reg;

endmodule

// ===== test/opcd_monitor.sv
// Checker for the two channel dividers, watching top ports only.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ns
module opcd_monitor #(
   parameter int ADDR_W = 10
) (
   input wire logic              i_clk,
   input wire logic              i_arst_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [7:0]        i_wdata,
   input wire logic              i_wr,
   input wire logic              i_rd,
   input wire logic [1:0]        i_in_select,
   input wire logic              i_osc_level,
   input wire logic              i_ext_level,
   input wire logic              i_align_req,
   input wire logic [7:0]        o_rdata,
   input wire logic              o_pair0_output_a,
   input wire logic              o_pair0_output_b,
   input wire logic              o_pair1_output_a,
   input wire logic              o_pair1_output_b,
   input wire logic              o_duty_fix_on0,
   input wire logic              o_div0_powered_down,
   input wire logic              o_div1_powered_down
);
   import opcd_pkg::*;
   logic [7:0] len1_reg;   // Divider 1 lengths as written
   logic [7:0] ctl1_reg;   // Divider 1 control as written
   logic       dir0_reg;   // Pair 0 direct route
   logic       dir1_reg;   // Pair 1 direct route

   // Mirror of software writes; strobes never overlap so no read race
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         len1_reg <= 8'h00;
         ctl1_reg <= 8'h00;
         dir0_reg <= 1'b0;
         dir1_reg <= 1'b0;
      end else if (i_wr) begin
         if (i_addr == OFS_DIV1_LEN) len1_reg <= i_wdata;
         if (i_addr == OFS_DIV1_CTL) ctl1_reg <= i_wdata;
         if (i_addr == OFS_DIV0_ROUTE) dir0_reg <= i_wdata[ROUTE_DIRECT];
         if (i_addr == OFS_DIV1_ROUTE) dir1_reg <= i_wdata[ROUTE_DIRECT];
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   property p_pair_eq;
      o_pair0_output_a == o_pair0_output_b && o_pair1_output_a == o_pair1_output_b;
   endproperty
   a_pair_eq: assert property (p_pair_eq) else $error("pair pins differ");
   property p_duty0;
      i_wr && i_addr == OFS_DIV0_ROUTE |-> ##2 o_duty_fix_on0 == !$past(i_wdata[ROUTE_DUTY], 2);
   endproperty
   a_duty0: assert property (p_duty0) else $error("duty enable wrong");
   property p_pdown1;
      i_wr && i_addr == OFS_DIV1_CTL |-> ##2 o_div1_powered_down == $past(i_wdata[CTL_BYPASS], 2);
   endproperty
   a_pdown1: assert property (p_pdown1) else $error("power down wrong");
   property p_rd_len1;
      i_rd && i_addr == OFS_DIV1_LEN |=> o_rdata == len1_reg;
   endproperty
   a_rd_len1: assert property (p_rd_len1) else $error("length readback wrong");
   property p_bypass0;
      // Power-down flag lags the bypass bit by one edge
      i_in_select == SEL_OSC ##1 o_div0_powered_down && !dir0_reg
      |=> o_pair0_output_a == $past(i_osc_level, 2);
   endproperty
   a_bypass0: assert property (p_bypass0) else $error("bypass path wrong");
   property p_direct0;
      dir0_reg && i_in_select == SEL_OSC |=> o_pair0_output_a == $past(i_osc_level);
   endproperty
   a_direct0: assert property (p_direct0) else $error("osc route wrong");
   property p_direct1;
      dir1_reg && i_in_select == SEL_EXT_CLK |=> o_pair1_output_a == $past(i_ext_level);
   endproperty
   a_direct1: assert property (p_direct1) else $error("ext route wrong");
   property p_force1;
      (ctl1_reg[7:5] == 3'h3 && !dir1_reg) [*3] |-> o_pair1_output_a;
   endproperty
   a_force1: assert property (p_force1) else $error("force high missing");
   property p_align1;
      i_align_req && ctl1_reg == 8'h00 && len1_reg == 8'h00 && !dir1_reg ##1 !i_align_req
      |-> ##1 !o_pair1_output_a ##1 !o_pair1_output_a ##1 o_pair1_output_a;
   endproperty
   a_align1: assert property (p_align1) else $error("restart timing wrong");
   c_align1: cover property (p_align1);
   c_force1: cover property (ctl1_reg[CTL_FORCE] && o_pair1_output_a);
   c_ext0: cover property (dir0_reg && i_in_select == SEL_EXT_CLK);
endmodule

// ===== test/opcd_pair_model.sv
// Behavioural differential buffer fed by one output pair.
// Assumes pair pins change only just after the divider clock edge.
`timescale 1ns/1ns
module opcd_pair_model (
   input  wire logic i_a,
   input  wire logic i_b,
   output logic      o_p,
   output logic      o_n
);
   // True side follows pin a, complement side inverts pin b
   always_comb begin
      o_p = i_a;
      o_n = !i_b;
   end
endmodule

// ===== test/opcd_top_bench.sv
// Self-checking bench for the two channel dividers and registers.
// Assumes one divider input clock and an asynchronous reset.
`timescale 1ns/1ns
module opcd_top_bench;
   import opcd_pkg::*;
   typedef struct {
      logic d; logic [7:0] len; logic [7:0] ctl; logic [7:0] first; logic [7:0] w1; logic [7:0] w2;
   } opcd_row_t;
   // Divider, lengths, control; edges to first swing, then two widths
   opcd_row_t   rows [5] = '{'{1'b1, 8'h00, 8'h00, 8'h03, 8'h01, 8'h01},
      '{1'b1, 8'h31, 8'h02, 8'h08, 8'h02, 8'h04}, '{1'b1, 8'h0F, 8'h10, 8'h12, 8'h01, 8'h10},
      '{1'b0, 8'h52, 8'h03, 8'h0B, 8'h03, 8'h06}, '{1'b0, 8'h00, 8'h1F, 8'h12, 8'h01, 8'h01}};
   // Reset image, address beside value; the last one is unmapped
   logic [17:0] rst_rows [7] = '{{OFS_DIV0_LEN, 8'h00}, {OFS_DIV0_CTL, 8'h80},
      {OFS_DIV0_ROUTE, 8'h00}, {OFS_DIV1_LEN, 8'h00}, {OFS_DIV1_CTL, 8'h00},
      {OFS_DIV1_ROUTE, 8'h00}, {10'h1A0, 8'h00}};
   logic        i_clk, i_arst_n, i_wr, i_rd, i_osc_level, i_ext_level, i_align_req;
   logic [9:0]  i_addr;
   logic [7:0]  i_wdata, o_rdata, v;
   logic [1:0]  i_in_select, tick;
   logic        o_duty_fix_on0, o_duty_fix_on1, o_div0_powered_down, o_div1_powered_down;
   logic        pa0, pb0, pa1, pb1, p0_p, p0_n, p1_p, p1_n;
   int          error_cnt, comparisons;

   opcd_top i_opcd_top (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_in_select(i_in_select), .i_osc_level(i_osc_level),
      .i_ext_level(i_ext_level), .i_align_req(i_align_req), .o_rdata(o_rdata),
      .o_pair0_output_a(pa0), .o_pair0_output_b(pb0), .o_pair1_output_a(pa1), .o_pair1_output_b(pb1),
      .o_duty_fix_on0(o_duty_fix_on0), .o_duty_fix_on1(o_duty_fix_on1),
      .o_div0_powered_down(o_div0_powered_down), .o_div1_powered_down(o_div1_powered_down));
   opcd_pair_model i_opcd_pair_model_0 (.i_a(pa0), .i_b(pb0), .o_p(p0_p), .o_n(p0_n));
   opcd_pair_model i_opcd_pair_model_1 (.i_a(pa1), .i_b(pb1), .o_p(p1_p), .o_n(p1_n));

   always #20 i_clk = !i_clk;
   // Oscillator toggles every cycle, external clock every two
   always @(posedge i_clk) begin
      tick        <= tick + 2'h1;
      i_osc_level <= !i_osc_level;
      i_ext_level <= tick[1];
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle strobes; an idle edge between accesses keeps drives apart
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic pulse_align;
      @(posedge i_clk);
      i_align_req <= 1'b1;
      @(posedge i_clk);
      i_align_req <= 1'b0;
   endtask
   // Counts edges while the buffer output stays at one level
   task automatic wait_flip(input logic d, input logic lvl, inout logic [7:0] n);
      do begin
         @(posedge i_clk);
         #1 n++;
      end while ((d ? p1_p : p0_p) === lvl && n < 8'h40);
   endtask
   task automatic run_row(input opcd_row_t r);
      logic [7:0] n, c1, c2;
      n  = 8'h02;
      c1 = 8'h00;
      c2 = 8'h00;
      wr(r.d ? OFS_DIV1_LEN : OFS_DIV0_LEN, r.len);
      wr(r.d ? OFS_DIV1_CTL : OFS_DIV0_CTL, r.ctl);
      rd(r.d ? OFS_DIV1_LEN : OFS_DIV0_LEN, v);
      chk(v, r.len);
      pulse_align();
      // Pins lag by two edges, so the first two cannot swing
      repeat (2) @(posedge i_clk);
      wait_flip(r.d, r.ctl[CTL_START], n);
      wait_flip(r.d, !r.ctl[CTL_START], c1);
      wait_flip(r.d, r.ctl[CTL_START], c2);
      chk(n, r.first);
      chk(c1, r.w1);
      chk(c2, r.w2);
      $display("test row done");
   endtask
   task automatic stop_test;
      $display("Counts: %0d compares, %0d errors", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Watchdog: run needs about 210 cycles, allow 4000
   initial begin
      #160000;
      error_cnt++;
      stop_test();
   end

   initial begin
      {i_clk, i_arst_n, i_wr, i_rd, i_osc_level, i_ext_level, i_align_req} = 7'h00;
      {i_addr, i_wdata, tick, error_cnt, comparisons} = '0;
      i_in_select = SEL_OSC;
      #50 chk({4'h0, o_div0_powered_down, o_div1_powered_down, o_duty_fix_on1, o_duty_fix_on0},
              8'h0B);
      repeat (2) @(posedge i_clk);
      i_arst_n <= 1'b1;
      @(posedge i_clk);
      #1 v = {7'h00, i_osc_level};
      repeat (2) @(posedge i_clk);
      #1 chk({7'h00, p0_p}, v);
      wr(10'h1A0, 8'hFF);
      foreach (rst_rows[i]) begin
         rd(rst_rows[i][17:8], v);
         chk(v, rst_rows[i][7:0]);
      end
      $display("test reset image done");
      foreach (rows[i]) run_row(rows[i]);
      // Ignore bit set: alignment must not park divider 1
      wr(OFS_DIV1_CTL, 8'h4F);
      pulse_align();
      rd(OFS_STATUS, v);
      chk({7'h00, v[STAT_WAIT1]}, 8'h00);
      wr(OFS_DIV1_CTL, 8'h0F);
      pulse_align();
      rd(OFS_STATUS, v);
      chk({7'h00, v[STAT_WAIT1]}, 8'h01);
      // Forced high needs the ignore bit too
      wr(OFS_DIV1_CTL, 8'h60);
      repeat (3) @(posedge i_clk);
      #1 chk({6'h00, p1_p, p1_n}, 8'h02);
      wr(OFS_DIV1_LEN, 8'h00);
      wr(OFS_DIV1_CTL, 8'h20);
      pulse_align();
      repeat (4) @(posedge i_clk);
      #1 v = {7'h00, p1_p};
      @(posedge i_clk);
      #1 chk({7'h00, p1_p ^ v[0]}, 8'h01);
      $display("test ignore and force done");
      wr(OFS_DIV0_ROUTE, 8'h03);
      @(posedge i_clk);
      #1 chk({7'h00, o_duty_fix_on0}, 8'h00);
      wr(OFS_DIV1_ROUTE, 8'h03);
      @(posedge i_clk);
      #1 chk({7'h00, o_duty_fix_on1}, 8'h00);
      @(posedge i_clk);
      i_in_select <= SEL_EXT_CLK;
      @(posedge i_clk);
      #1 v = {7'h00, i_ext_level};
      @(posedge i_clk);
      #1 chk({6'h00, p1_p, p0_p}, {6'h00, v[0], v[0]});
      @(posedge i_clk);
      i_in_select <= SEL_DIVIDED;
      run_row('{1'b0, 8'h00, 8'h00, 8'h03, 8'h01, 8'h01});
      wr(OFS_DIV1_CTL, 8'h80);
      @(posedge i_clk);
      #1 chk({7'h00, o_div1_powered_down}, 8'h01);
      $display("test routing done");
      stop_test();
   end
endmodule

bind opcd_top opcd_monitor #(.ADDR_W(ADDR_W)) i_opcd_monitor (.i_clk(i_clk), .i_arst_n(i_arst_n),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_in_select(i_in_select),
   .i_osc_level(i_osc_level), .i_ext_level(i_ext_level), .i_align_req(i_align_req),
   .o_rdata(o_rdata), .o_pair0_output_a(o_pair0_output_a), .o_pair0_output_b(o_pair0_output_b),
   .o_pair1_output_a(o_pair1_output_a), .o_pair1_output_b(o_pair1_output_b),
   .o_duty_fix_on0(o_duty_fix_on0), .o_div0_powered_down(o_div0_powered_down),
   .o_div1_powered_down(o_div1_powered_down));
